// File: rtl/nvmcs_pkg.sv
// Package with register map, field positions and timing for the memory control block
package nvmcs_pkg;
  // Register offsets and unlock code
  localparam logic [7:0] ADDR_CYCLE_COUNT = 8'h88;
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'h89;
  localparam logic [7:0] ADDR_LIVE_CRC = 8'h8a;
  localparam logic [7:0] ADDR_PTR_HIGH = 8'h8b;
  localparam logic [7:0] ADDR_PTR_LOW = 8'h8c;
  localparam logic [7:0] ADDR_EE_PORT = 8'h8d;
  localparam logic [7:0] ADDR_SRAM_PORT = 8'h8e;
  localparam logic [7:0] ADDR_UNLOCK = 8'h8f;
  localparam logic [7:0] UNLOCK_CODE = 8'hea;
  // Control and status field positions
  localparam int BIT_COPY = 6;
  localparam int BIT_CRC_ERR = 5;
  localparam int BIT_AUTO_CRC = 4;
  localparam int BIT_LOAD = 3;
  localparam int BIT_BUSY = 2;
  localparam int BIT_RSV_SC = 1;
  localparam int BIT_PROG = 0;
  // Reset values, CRC polynomial and counter maximum
  localparam logic RST_AUTO_CRC = 1'b1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CRC_SEED = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  // Memory geometry: image bytes, last byte holds stored CRC
  localparam int MEM_WORDS = 512;
  localparam logic [8:0] IMG_LAST = 9'h0ff;
  // Program cycle time
  localparam int CLK_HZ = 20000000;
  localparam int PROG_TIME_MS = 230;
  localparam int PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);
  // Sequencer states
  typedef enum logic [3:0] {
    NVMCS_IDLE = 4'b0001,
    NVMCS_LOAD = 4'b0010,
    NVMCS_COPY = 4'b0100,
    NVMCS_PROG = 4'b1000
  } nvmcs_state_t;
endpackage

// File: rtl/nvmcs_sequencer.sv
// Non-volatile memory load, copy-back and program sequencer with its registers
// Overview of operation
// - Copy bit copies live registers to SRAM, self-clears
// - Copy destination page from page select input
// - CRC mismatch during load sets read-only error flag
// - Auto CRC enabled: program writes computed CRC byte
// - Load EEPROM after reset or load bit, self-clears
// - Register reads not answered during load
// - Load advances only while always-on clock runs
// - Busy flag high during program, EEPROM blocked
// - Program starts only after unlock code transaction
// - Program cycle lasts about 230 ms
// - Live CRC byte readable, resets to zero
// - Pointer high bits 3:0, bits 7:4 reserved
// - EEPROM/SRAM use pointer 8:0, ROM 11:0
// - Control bit 1 self-clears, bit 7 reserved
// - Pointer low byte in its own register
// - Program counter increments, saturates at maximum
// - Data port reads advance address within transaction
`timescale 1ns/1ps
module nvmcs_sequencer #(
  parameter int PROG_COUNT = nvmcs_pkg::PROG_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Register access from the serial host slave
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic txn_end_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rd_valid_out,
  // Always-on clock status and copy page
  input wire logic aon_clk_active_in,
  input wire logic copy_page_in,
  // Live configuration register port
  output logic cfg_wr_out,
  output logic [7:0] cfg_addr_out,
  output logic [7:0] cfg_data_out,
  input wire logic [7:0] cfg_rd_data_in,
  // Full memory pointer for the ROM port
  output logic [11:0] memory_pointer_out
);
  // CRC-8 over one byte
  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ nvmcs_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
  nvmcs_pkg::nvmcs_state_t state_q;
  logic [7:0] ee_mem [nvmcs_pkg::MEM_WORDS];
  logic [7:0] sram_mem [nvmcs_pkg::MEM_WORDS];
  logic [22:0] tick_q;
  logic [11:0] ptr_q;
  logic [8:0] idx_q, ee_off_q, sram_off_q, ee_addr, sram_addr;
  logic [7:0] crc_q, live_crc_q, count_q, prog_byte;
  logic crc_err_q, auto_crc_q, copy_pend_q, load_pend_q, prog_pend_q, rsv_sc_q, copy_page_q, unlocked_q;
  logic unlock_txn_q, other_txn_q, wr_ctl, busy, loading, load_step, last, ee_rd, sram_acc;
  ////////////////////////////////////////////////////////////////////////////
  // Decodes and shared terms
  assign wr_ctl = reg_wr_in && (reg_addr_in == nvmcs_pkg::ADDR_CTRL_STATUS);
  assign busy = (state_q == nvmcs_pkg::NVMCS_PROG);
  assign loading = (state_q == nvmcs_pkg::NVMCS_LOAD);
  assign load_step = loading && aon_clk_active_in;
  assign last = (idx_q == nvmcs_pkg::IMG_LAST);
  assign ee_rd = reg_rd_in && !loading && !busy && (reg_addr_in == nvmcs_pkg::ADDR_EE_PORT);
  assign sram_acc = (reg_rd_in || reg_wr_in) && (reg_addr_in == nvmcs_pkg::ADDR_SRAM_PORT);
  assign ee_addr = ptr_q[8:0] + ee_off_q;
  assign sram_addr = ptr_q[8:0] + sram_off_q;
  assign memory_pointer_out = ptr_q;
  // Last image byte becomes the computed CRC when auto CRC is on
  assign prog_byte = (last && auto_crc_q) ? crc_q : sram_mem[idx_q];
  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: load, copy-back and program
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_q <= nvmcs_pkg::NVMCS_IDLE;
      idx_q <= 9'h000;
      tick_q <= 23'h000000;
      crc_q <= nvmcs_pkg::CRC_SEED;
    end
    else
    begin
      case (state_q)
        nvmcs_pkg::NVMCS_IDLE:
        begin
          idx_q <= 9'h000;
          tick_q <= 23'h000000;
          crc_q <= nvmcs_pkg::CRC_SEED;
          if (load_pend_q)
            state_q <= nvmcs_pkg::NVMCS_LOAD;
          else if (copy_pend_q)
            state_q <= nvmcs_pkg::NVMCS_COPY;
          else if (prog_pend_q)
            state_q <= nvmcs_pkg::NVMCS_PROG;
        end
        nvmcs_pkg::NVMCS_LOAD:
        begin
          if (load_step)
          begin
            idx_q <= idx_q + 9'h001;
            if (!last)
              crc_q <= crc_step(crc_q, ee_mem[idx_q]);
            else
              state_q <= nvmcs_pkg::NVMCS_IDLE;
          end
        end
        nvmcs_pkg::NVMCS_COPY:
        begin
          idx_q <= idx_q + 9'h001;
          if (idx_q == nvmcs_pkg::IMG_LAST - 9'h001)
            state_q <= nvmcs_pkg::NVMCS_IDLE;
        end
        nvmcs_pkg::NVMCS_PROG:
        begin
          tick_q <= tick_q + 23'h000001;
          if (idx_q <= nvmcs_pkg::IMG_LAST)
          begin
            idx_q <= idx_q + 9'h001;
            if (!last)
              crc_q <= crc_step(crc_q, sram_mem[idx_q]);
          end
          if (tick_q == 23'(PROG_COUNT - 1))
            state_q <= nvmcs_pkg::NVMCS_IDLE;
        end
        default: state_q <= nvmcs_pkg::NVMCS_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Live configuration register port
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cfg_wr_out <= 1'b0;
      cfg_addr_out <= 8'h00;
      cfg_data_out <= 8'h00;
    end
    else
    begin
      cfg_wr_out <= load_step && !last;
      // Copy presents the index it reads in the next cycle, starting from zero
      cfg_addr_out <= (state_q == nvmcs_pkg::NVMCS_COPY) ? idx_q[7:0] + 8'h01 : (loading ? idx_q[7:0] : 8'h00);
      cfg_data_out <= ee_mem[idx_q];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // CRC result and error flag
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      live_crc_q <= nvmcs_pkg::RST_BYTE;
      crc_err_q <= 1'b0;
    end
    else if (load_step && last)
    begin
      live_crc_q <= crc_q;
      crc_err_q <= (crc_q != ee_mem[idx_q]);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Memory arrays
  always_ff @(posedge sys_clk_in)
  begin
    if (busy && idx_q <= nvmcs_pkg::IMG_LAST)
      ee_mem[idx_q] <= prog_byte;
  end
  always_ff @(posedge sys_clk_in)
  begin
    if (state_q == nvmcs_pkg::NVMCS_COPY)
      sram_mem[{copy_page_q, idx_q[7:0]}] <= cfg_rd_data_in;
    else if (sram_acc && reg_wr_in)
      sram_mem[sram_addr] <= reg_wdata_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Command bits; a load or copy request in the finishing cycle wins over the clear, a program request while busy is ignored
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      load_pend_q <= 1'b1;
      copy_pend_q <= 1'b0;
      prog_pend_q <= 1'b0;
      rsv_sc_q <= 1'b0;
      auto_crc_q <= nvmcs_pkg::RST_AUTO_CRC;
      copy_page_q <= 1'b0;
    end
    else
    begin
      rsv_sc_q <= wr_ctl && reg_wdata_in[nvmcs_pkg::BIT_RSV_SC];
      if (state_q == nvmcs_pkg::NVMCS_IDLE && copy_pend_q)
        copy_page_q <= copy_page_in;
      if (wr_ctl)
        auto_crc_q <= reg_wdata_in[nvmcs_pkg::BIT_AUTO_CRC];
      if (wr_ctl && reg_wdata_in[nvmcs_pkg::BIT_LOAD] && !busy)
        load_pend_q <= 1'b1;
      else if (load_step && last)
        load_pend_q <= 1'b0;
      if (wr_ctl && reg_wdata_in[nvmcs_pkg::BIT_COPY])
        copy_pend_q <= 1'b1;
      else if (state_q == nvmcs_pkg::NVMCS_COPY && idx_q == nvmcs_pkg::IMG_LAST - 9'h001)
        copy_pend_q <= 1'b0;
      if (wr_ctl && reg_wdata_in[nvmcs_pkg::BIT_PROG] && unlocked_q && !busy)
        prog_pend_q <= 1'b1;
      else if (busy && tick_q == 23'(PROG_COUNT - 1))
        prog_pend_q <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Unlock tracking: only the transaction just before counts
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      unlocked_q <= 1'b0;
      unlock_txn_q <= 1'b0;
      other_txn_q <= 1'b0;
    end
    else if (txn_end_in)
    begin
      unlocked_q <= unlock_txn_q && !other_txn_q;
      unlock_txn_q <= 1'b0;
      other_txn_q <= 1'b0;
    end
    else if (reg_wr_in && reg_addr_in == nvmcs_pkg::ADDR_UNLOCK && reg_wdata_in == nvmcs_pkg::UNLOCK_CODE)
      unlock_txn_q <= 1'b1;
    else if (reg_wr_in || reg_rd_in)
      other_txn_q <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Program counter, pointer and data port offsets
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      count_q <= nvmcs_pkg::RST_BYTE;
      ptr_q <= 12'h000;
      ee_off_q <= 9'h000;
      sram_off_q <= 9'h000;
    end
    else
    begin
      if (busy && tick_q == 23'(PROG_COUNT - 1) && count_q != nvmcs_pkg::COUNT_MAX)
        count_q <= count_q + 8'h01;
      if (reg_wr_in && reg_addr_in == nvmcs_pkg::ADDR_PTR_HIGH)
        ptr_q[11:8] <= reg_wdata_in[3:0];
      if (reg_wr_in && reg_addr_in == nvmcs_pkg::ADDR_PTR_LOW)
        ptr_q[7:0] <= reg_wdata_in;
      if (txn_end_in)
        ee_off_q <= 9'h000;
      else if (ee_rd)
        ee_off_q <= ee_off_q + 9'h001;
      if (txn_end_in)
        sram_off_q <= 9'h000;
      else if (sram_acc && state_q != nvmcs_pkg::NVMCS_COPY)
        sram_off_q <= sram_off_q + 9'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Read data, answered one cycle after the request
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      reg_rdata_out <= 8'h00;
      reg_rd_valid_out <= 1'b0;
    end
    else
    begin
      reg_rd_valid_out <= reg_rd_in && !loading;
      case (reg_addr_in)
        nvmcs_pkg::ADDR_CYCLE_COUNT: reg_rdata_out <= count_q;
        nvmcs_pkg::ADDR_CTRL_STATUS: reg_rdata_out <= {1'b0, copy_pend_q, crc_err_q, auto_crc_q,
                                                       load_pend_q, busy, rsv_sc_q, prog_pend_q};
        nvmcs_pkg::ADDR_LIVE_CRC: reg_rdata_out <= live_crc_q;
        nvmcs_pkg::ADDR_PTR_HIGH: reg_rdata_out <= {4'h0, ptr_q[11:8]};
        nvmcs_pkg::ADDR_PTR_LOW: reg_rdata_out <= ptr_q[7:0];
        nvmcs_pkg::ADDR_EE_PORT: reg_rdata_out <= ee_rd ? ee_mem[ee_addr] : 8'h00;
        nvmcs_pkg::ADDR_SRAM_PORT: reg_rdata_out <= sram_mem[sram_addr];
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end
endmodule

// File: verification/nvmcs_seq_sva.sv
// Port assertions for the memory control sequencer
`timescale 1ns/1ps
module nvmcs_seq_sva #(
  parameter int PROG_COUNT = 300
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Register access
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rd_valid_out,
  // Load side
  input wire logic aon_clk_active_in,
  input wire logic cfg_wr_out,
  input wire logic [7:0] cfg_addr_out,
  input wire logic [11:0] memory_pointer_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////
  // Register bus answers
  AST_RD_ANS: assert property (
    reg_rd_valid_out |-> $past(reg_rd_in)) else $error("answer without read");
  AST_PTR_HI: assert property (
    reg_wr_in && reg_addr_in == 8'h8b |=> memory_pointer_out[11:8] == $past(reg_wdata_in[3:0]))
    else $error("pointer high not taken");
  AST_PTR_LO: assert property (
    reg_wr_in && reg_addr_in == 8'h8c |=> memory_pointer_out[7:0] == $past(reg_wdata_in))
    else $error("pointer low not taken");
  AST_HI_RSV: assert property (
    reg_rd_in && reg_addr_in == 8'h8b |=> !reg_rd_valid_out || reg_rdata_out[7:4] == 4'h0)
    else $error("pointer high reserved bits set");
  AST_CTL_B7: assert property (
    reg_rd_in && reg_addr_in == 8'h89 |=> !reg_rd_valid_out || !reg_rdata_out[7])
    else $error("control bit 7 set");
  ////////////////////////////////////////////////////////////
  // Load writes into live registers
  AST_CFG_RANGE: assert property (
    cfg_wr_out |-> cfg_addr_out != 8'hff) else $error("load wrote crc slot");
  AST_CFG_STEP: assert property (
    cfg_wr_out && $past(cfg_wr_out) |-> cfg_addr_out == $past(cfg_addr_out) + 8'h01)
    else $error("load index skipped");
  AST_AON: assert property (
    cfg_wr_out |-> $past(aon_clk_active_in)) else $error("load ran without clock");
  AST_RD_LOAD: assert property (
    cfg_wr_out && reg_rd_in |=> !reg_rd_valid_out) else $error("read answered during load");
endmodule

// File: verification/nvmcs_live_regs.sv
// Live configuration register file model
`timescale 1ns/1ps
module nvmcs_live_regs (
  // Clock
  input wire logic sys_clk_in,
  // Live register port
  input wire logic wr_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] data_in,
  output logic [7:0] rdata_out,
  // Load write count
  output int wr_count_out
);
  logic [7:0] mem [256];
  // Distinct start contents
  initial
  begin
    wr_count_out = 0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
  end
  // Answer at once from the presented index
  assign rdata_out = mem[addr_in];
  // Take load writes
  always @(posedge sys_clk_in)
    if (wr_in === 1'b1)
    begin
      mem[addr_in] <= data_in;
      wr_count_out <= wr_count_out + 1;
    end
endmodule

// File: verification/nvm_control_commit_sequencer_bench.sv
// Self-checking bench for the memory control sequencer
`timescale 1ns/1ps
module nvm_control_commit_sequencer_bench;
  localparam int PC = 300;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic txn_end_in = 1'b0;
  logic aon_clk_active_in = 1'b0;
  logic copy_page_in = 1'b0;
  logic [7:0] reg_rdata_out, cfg_addr_out, cfg_data_out, cfg_rd_data_in, rd_q, cnt;
  logic reg_rd_valid_out, cfg_wr_out, ok;
  logic [11:0] memory_pointer_out;
  int wr_count;
  int errors = 0;
  int total_checks = 0;
  // Clock
  initial
    forever #25 sys_clk_in = ~sys_clk_in;
  nvmcs_sequencer #(.PROG_COUNT(PC)) u_dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .txn_end_in(txn_end_in), .reg_rdata_out(reg_rdata_out),
    .reg_rd_valid_out(reg_rd_valid_out), .aon_clk_active_in(aon_clk_active_in),
    .copy_page_in(copy_page_in), .cfg_wr_out(cfg_wr_out), .cfg_addr_out(cfg_addr_out),
    .cfg_data_out(cfg_data_out), .cfg_rd_data_in(cfg_rd_data_in),
    .memory_pointer_out(memory_pointer_out));
  nvmcs_live_regs u_live (.sys_clk_in(sys_clk_in), .wr_in(cfg_wr_out), .addr_in(cfg_addr_out),
    .data_in(cfg_data_out), .rdata_out(cfg_rd_data_in), .wr_count_out(wr_count));
  ////////////////////////////////////////////////////////////
  // Bus tasks, all entered just after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    step(1);
    reg_wr_in = 1'b0;
    step(1);
  endtask
  task automatic txn();
    txn_end_in = 1'b1;
    step(1);
    txn_end_in = 1'b0;
    step(1);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    step(1);
    reg_rd_in = 1'b0;
    ok = reg_rd_valid_out;
    rd_q = reg_rdata_out;
    step(1);
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // Reference CRC-8 over the image pattern 0..254
  function automatic logic [7:0] ref_crc();
    logic [7:0] c;
    c = nvmcs_pkg::CRC_SEED;
    for (int i = 0; i < 255; i++)
    begin
      c = c ^ 8'(i);
      for (int b = 0; b < 8; b++)
        c = c[7] ? ((c << 1) ^ nvmcs_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_boot();
    step(20);
    rd(8'h8b);
    chk(8'h00, {7'h00, ok});
    chk(8'h00, 8'(wr_count));
    aon_clk_active_in = 1'b1;
    step(300);
    chk(8'hff, 8'(wr_count));
    rd(8'h89);
    chk(8'h10, rd_q & 8'h18);
    $display("test_boot done");
  endtask
  task automatic test_pointer();
    rd(8'h8b);
    chk(8'h00, rd_q);
    wr(8'h8b, 8'hff);
    wr(8'h8c, 8'h34);
    rd(8'h8b);
    chk(8'h0f, rd_q);
    chk(8'hf3, memory_pointer_out[11:4]);
    $display("test_pointer done");
  endtask
  task automatic test_copy();
    wr(8'h8c, 8'h03);
    wr(8'h8b, 8'h00);
    txn();
    rd(8'h8d);
    chk(8'h03, rd_q);
    rd(8'h8d);
    chk(8'h04, rd_q);
    txn();
    copy_page_in = 1'b1;
    wr(8'h89, 8'h50);
    txn();
    rd(8'h89);
    chk(8'h40, rd_q & 8'h40);
    step(260);
    rd(8'h89);
    chk(8'h00, rd_q & 8'h40);
    wr(8'h8b, 8'h01);
    txn();
    rd(8'h8e);
    chk(8'h03, rd_q);
    rd(8'h8e);
    chk(8'h04, rd_q);
    txn();
    $display("test_copy done");
  endtask
  task automatic test_prog();
    wr(8'h8c, 8'h00);
    wr(8'h8b, 8'h00);
    txn();
    for (int i = 0; i < 255; i++)
      wr(8'h8e, 8'(i));
    txn();
    rd(8'h88);
    cnt = (rd_q == 8'hff) ? rd_q : rd_q + 8'h01;
    txn();
    wr(8'h89, 8'h11);
    txn();
    rd(8'h89);
    chk(8'h00, rd_q & 8'h04);
    txn();
    wr(8'h8f, 8'hea);
    txn();
    wr(8'h89, 8'h11);
    txn();
    rd(8'h89);
    chk(8'h04, rd_q & 8'h04);
    rd(8'h8d);
    chk(8'h00, rd_q);
    step(PC - 20);
    rd(8'h89);
    chk(8'h04, rd_q & 8'h04);
    step(40);
    rd(8'h89);
    chk(8'h00, rd_q & 8'h05);
    rd(8'h88);
    chk(cnt, rd_q);
    $display("test_prog done");
  endtask
  task automatic test_reload();
    txn();
    wr(8'h89, 8'h18);
    txn();
    rd(8'h89);
    chk(8'h00, {7'h00, ok});
    step(300);
    rd(8'h89);
    chk(8'h10, rd_q & 8'h38);
    chk(8'hfe, 8'(wr_count));
    rd(8'h8a);
    chk(ref_crc(), rd_q);
    $display("test_reload done");
  endtask
  // Main sequence
  initial
  begin
    step(8);
    rst_b_in = 1'b1;
    test_boot();
    test_pointer();
    test_prog();
    test_reload();
    test_copy();
    end_of_test();
  end
  // Watchdog
  initial
  begin
    #400000;
    errors++;
    end_of_test();
  end
endmodule
bind nvmcs_sequencer nvmcs_seq_sva #(.PROG_COUNT(PROG_COUNT)) u_sva (.sys_clk_in(sys_clk_in),
  .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .reg_rd_valid_out(reg_rd_valid_out),
  .aon_clk_active_in(aon_clk_active_in), .cfg_wr_out(cfg_wr_out), .cfg_addr_out(cfg_addr_out),
  .memory_pointer_out(memory_pointer_out));
